// ### src/epm_modify.sv
// Sequencer for the permission restrict and type change leaf operations.
`timescale 1ns/1ps
`include "epm_defs.svh"

module epm_modify import epm_pkg::*; (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Operation request
	input  wire logic         op_start,
	input  wire logic [7:0]   op_leaf,
	input  wire logic [1:0]   op_cpl,
	input  wire logic         long_mode,
	input  wire logic         gen2_present,
	input  wire logic [63:0]  info_ptr,
	input  wire logic [63:0]  page_ptr,
	// Operand environment
	input  wire logic         info_seg_ok,
	input  wire logic         page_seg_ok,
	input  wire logic         info_locked,
	input  wire logic         page_locked,
	input  wire logic         owner_locked,
	input  wire logic         info_readable,
	input  wire logic         page_rw_ok,
	input  wire logic         page_in_cache,
	input  wire logic         page_in_enclave,
	input  wire logic [511:0] info_block,
	input  wire logic [63:0]  owner_addr_in,
	// Page metadata map
	input  wire epm_meta_t    meta_rd,
	input  wire epm_env_t     env,
	output epm_meta_t         meta_wr,
	output logic              meta_we,
	// Completion
	output logic              busy,
	output logic              done,
	output logic              fault_gp,
	output logic              fault_pf,
	output logic [63:0]       fault_addr,
	output logic              failure_flag,
	output logic [63:0]       result_register,
	output logic [4:0]        arith_flags,
	output logic [63:0]       owner_struct_addr
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Low address bits clear
	function automatic logic is_aligned(input logic [63:0] a, input int bits);
		logic [63:0] m;
		m = (64'h1 << bits) - 64'h1;
		return (a & m) == 64'h0;
	endfunction

	// Upper bits sign-extend the top implemented bit
	function automatic logic is_canonical(input logic [63:0] a);
		return (&a[63:`EPM_CANON_MSB]) || !(|a[63:`EPM_CANON_MSB]);
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	epm_state_t   state_reg, state_next;        // Sequencer
	logic [7:0]   leaf_reg, leaf_next;          // Latched leaf
	logic [1:0]   cpl_reg, cpl_next;            // Latched privilege
	logic         lm_reg, lm_next;              // Latched 64-bit mode
	logic         g2_reg, g2_next;              // Latched feature
	logic [63:0]  iptr_reg, iptr_next;          // Info pointer
	logic [63:0]  pptr_reg, pptr_next;          // Page pointer
	logic [511:0] scratch_reg, scratch_next;    // Security info scratch
	epm_meta_t    mwr_reg, mwr_next;            // Metadata write data
	logic         mwe_reg, mwe_next;            // Metadata write strobe
	logic         done_reg, done_next;          // Completion pulse
	logic         gp_reg, gp_next;              // General protection fault
	logic         pf_reg, pf_next;              // Page fault
	logic [63:0]  faddr_reg, faddr_next;        // Faulting address
	logic         fail_reg, fail_next;          // Failure flag
	logic [63:0]  res_reg, res_next;            // Result register
	logic [4:0]   arith_reg, arith_next;        // Arithmetic flags
	logic [63:0]  owner_reg, owner_next;        // Owner struct address

	epm_outcome_t pre_outcome;   // Checks before the copy
	epm_outcome_t post_outcome;  // Checks after the copy
	logic         gate_ok;       // Leaf, privilege and segment checks pass
	logic         is_type_chg;   // Latched leaf is type change

	assign is_type_chg = (leaf_reg == `EPM_LEAF_TYPE_CHG);

	// ----------------------------------------------------------------
	// Post-copy check chain
	// ----------------------------------------------------------------
	epm_check u_check (
		.is_type_chg (is_type_chg),
		.scratch     (scratch_reg),
		.meta        (meta_rd),
		.env         (env),
		.outcome     (post_outcome)
	);

	// ----------------------------------------------------------------
	// Pre-copy checks in order
	// ----------------------------------------------------------------
	always_comb begin
		gate_ok = 1'b1;
		// Leaf, feature and privilege gate
		if (!((leaf_reg == `EPM_LEAF_RESTRICT) || is_type_chg) || !g2_reg) begin
			gate_ok = 1'b0;
		end else if (cpl_reg != `EPM_CPL_KERNEL) begin
			gate_ok = 1'b0;
		end else if (lm_reg && (!is_canonical(iptr_reg) || !is_canonical(pptr_reg))) begin
			gate_ok = 1'b0;
		end else if (!lm_reg && (!info_seg_ok || !page_seg_ok)) begin
			gate_ok = 1'b0;
		end else if (info_locked || page_locked) begin
			gate_ok = 1'b0;
		end
		pre_outcome = EPM_OK;
		if (!gate_ok) begin
			pre_outcome = EPM_GP;
		end else if (!is_aligned(iptr_reg, `EPM_INFO_ALIGN_BITS)) begin
			pre_outcome = EPM_GP;
		end else if (!is_aligned(pptr_reg, `EPM_PAGE_ALIGN_BITS)) begin
			pre_outcome = EPM_GP;
		end else if (!page_in_cache || !page_in_enclave) begin
			pre_outcome = EPM_PF;
		end else if (owner_locked || !info_readable || !page_rw_ok) begin
			pre_outcome = EPM_GP;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer next state and outputs
	// ----------------------------------------------------------------
	always_comb begin
		state_next   = state_reg;
		leaf_next    = leaf_reg;
		cpl_next     = cpl_reg;
		lm_next      = lm_reg;
		g2_next      = g2_reg;
		iptr_next    = iptr_reg;
		pptr_next    = pptr_reg;
		scratch_next = scratch_reg;
		mwr_next     = mwr_reg;
		mwe_next     = 1'b0;
		done_next    = 1'b0;
		gp_next      = 1'b0;
		pf_next      = 1'b0;
		faddr_next   = faddr_reg;
		fail_next    = fail_reg;
		res_next     = res_reg;
		arith_next   = arith_reg;
		owner_next   = owner_reg;
		case (state_reg)
			ST_IDLE: begin
				// Latch the request
				if (op_start) begin
					leaf_next  = op_leaf;
					cpl_next   = op_cpl;
					lm_next    = long_mode;
					g2_next    = gen2_present;
					iptr_next  = info_ptr;
					pptr_next  = page_ptr;
					state_next = ST_PRE;
				end
			end
			ST_PRE: begin
				// Fault ends the operation, else copy the info block
				if (pre_outcome != EPM_OK) begin
					done_next  = 1'b1;
					gp_next    = (pre_outcome == EPM_GP);
					pf_next    = (pre_outcome == EPM_PF);
					faddr_next = (pre_outcome == EPM_PF) ? pptr_reg : 64'h0;
					state_next = ST_IDLE;
				end else begin
					state_next = ST_COPY;
				end
			end
			ST_COPY: begin
				// Scratch copy and owner address, 32 bits outside 64-bit mode
				scratch_next = info_block;
				owner_next   = lm_reg ? owner_addr_in : {32'h0, owner_addr_in[31:0]};
				state_next   = ST_EVAL;
			end
			ST_EVAL: begin
				done_next  = 1'b1;
				state_next = ST_IDLE;
				arith_next = `EPM_ARITH_CLEAR;
				case (post_outcome)
					EPM_GP: begin
						gp_next    = 1'b1;
						faddr_next = 64'h0;
					end
					EPM_PF: begin
						pf_next    = 1'b1;
						faddr_next = pptr_reg;
					end
					EPM_CONFLICT: begin
						fail_next = 1'b1;
						res_next  = `EPM_ERR_CONFLICT;
					end
					EPM_NOT_CHG: begin
						fail_next = 1'b1;
						res_next  = `EPM_ERR_NOT_CHG;
					end
					default: begin
						fail_next = 1'b0;
						res_next  = `EPM_ERR_NONE;
						mwe_next  = 1'b1;
						mwr_next  = meta_rd;
						if (is_type_chg) begin
							// New type, no rights until accepted
							mwr_next.restrict_pend = 1'b0;
							mwr_next.modified      = 1'b1;
							mwr_next.rd            = 1'b0;
							mwr_next.wr            = 1'b0;
							mwr_next.ex            = 1'b0;
							mwr_next.ptype         = scratch_reg[`EPM_INFO_PT_MSB:`EPM_INFO_PT_LSB];
						end else begin
							// Mask can only narrow rights
							mwr_next.restrict_pend = 1'b1;
							mwr_next.rd = meta_rd.rd & scratch_reg[`EPM_INFO_R_BIT];
							mwr_next.wr = meta_rd.wr & scratch_reg[`EPM_INFO_W_BIT];
							mwr_next.ex = meta_rd.ex & scratch_reg[`EPM_INFO_X_BIT];
						end
					end
				endcase
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Register update
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg   <= ST_IDLE;
			leaf_reg    <= 8'h00;
			cpl_reg     <= 2'h0;
			lm_reg      <= 1'b0;
			g2_reg      <= 1'b0;
			iptr_reg    <= 64'h0;
			pptr_reg    <= 64'h0;
			scratch_reg <= 512'h0;
			mwr_reg     <= '0;
			mwe_reg     <= 1'b0;
			done_reg    <= 1'b0;
			gp_reg      <= 1'b0;
			pf_reg      <= 1'b0;
			faddr_reg   <= 64'h0;
			fail_reg    <= 1'b0;
			res_reg     <= `EPM_ERR_NONE;
			arith_reg   <= `EPM_ARITH_CLEAR;
			owner_reg   <= 64'h0;
		end else begin
			state_reg   <= state_next;
			leaf_reg    <= leaf_next;
			cpl_reg     <= cpl_next;
			lm_reg      <= lm_next;
			g2_reg      <= g2_next;
			iptr_reg    <= iptr_next;
			pptr_reg    <= pptr_next;
			scratch_reg <= scratch_next;
			mwr_reg     <= mwr_next;
			mwe_reg     <= mwe_next;
			done_reg    <= done_next;
			gp_reg      <= gp_next;
			pf_reg      <= pf_next;
			faddr_reg   <= faddr_next;
			fail_reg    <= fail_next;
			res_reg     <= res_next;
			arith_reg   <= arith_next;
			owner_reg   <= owner_next;
		end
	end

	// Busy as a flop: high from the cycle after the start
	logic busy_reg;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= (state_next != ST_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign meta_wr           = mwr_reg;
	assign meta_we           = mwe_reg;
	assign busy              = busy_reg;
	assign done              = done_reg;
	assign fault_gp          = gp_reg;
	assign fault_pf          = pf_reg;
	assign fault_addr        = faddr_reg;
	assign failure_flag      = fail_reg;
	assign result_register   = res_reg;
	assign arith_flags       = arith_reg;
	assign owner_struct_addr = owner_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_info_align: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == ST_PRE && gate_ok && |iptr_reg[5:0]) |=> (done_reg && gp_reg && !mwe_reg))
		else $error("misaligned info pointer did not fault");

	chk_page_align: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == ST_PRE && gate_ok && iptr_reg[5:0] == 6'h00 && |pptr_reg[11:0]) |=> (done_reg && gp_reg))
		else $error("misaligned page pointer did not fault");

	chk_cache_miss: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == ST_PRE && gate_ok && iptr_reg[5:0] == 6'h00 && pptr_reg[11:0] == 12'h000 && !page_in_cache)
		|=> (pf_reg && fault_addr == $past(pptr_reg)))
		else $error("page outside cache did not page fault");

	chk_privilege: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == ST_PRE && cpl_reg != 2'h0) |=> (gp_reg && done_reg))
		else $error("nonzero privilege did not fault");

	chk_fault_no_wr: assert property (@(posedge core_clk) disable iff (rst)
		(gp_reg || pf_reg || fail_reg && done_reg) |-> !mwe_reg)
		else $error("metadata written on a failing path");

	chk_rights_and: assert property (@(posedge core_clk) disable iff (rst)
		(mwe_reg && !is_type_chg) |-> (mwr_reg.restrict_pend
		&& mwr_reg.rd == ($past(meta_rd.rd) & scratch_reg[0])
		&& mwr_reg.wr == ($past(meta_rd.wr) & scratch_reg[1])
		&& mwr_reg.ex == ($past(meta_rd.ex) & scratch_reg[2])))
		else $error("rights not narrowed by mask");

	chk_fail_code: assert property (@(posedge core_clk) disable iff (rst)
		(done_reg && !gp_reg && !pf_reg) |-> (fail_reg ? (res_reg == 64'h7 || res_reg == 64'h14)
		: (res_reg == 64'h0 && mwe_reg)))
		else $error("result code does not match failure flag");

	chk_op_latency: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == ST_IDLE && op_start) |-> ##[2:4] done_reg)
		else $error("operation did not complete in four cycles");

	chk_arith_clear: assert property (@(posedge core_clk) disable iff (rst)
		done_reg |-> (arith_flags == 5'h00))
		else $error("arithmetic flags not cleared");

endmodule // epm_modify

// ### src/epm_defs.svh
// Constants for the enclave page modify block: leaf codes, field positions, error codes.
`ifndef EPM_DEFS_SVH
`define EPM_DEFS_SVH

// ----------------------------------------------------------------
// Leaf selectors and privilege
// ----------------------------------------------------------------
`define EPM_LEAF_RESTRICT   8'h0E
`define EPM_LEAF_TYPE_CHG   8'h0F
`define EPM_CPL_KERNEL      2'h0

// ----------------------------------------------------------------
// Operand alignment (low address bits that must be zero) and canonical address top bit
// ----------------------------------------------------------------
`define EPM_INFO_ALIGN_BITS 6
`define EPM_PAGE_ALIGN_BITS 12
`define EPM_CANON_MSB       47

// ----------------------------------------------------------------
// Security info block layout (flags word in the low 64 bits)
// ----------------------------------------------------------------
`define EPM_INFO_R_BIT      0
`define EPM_INFO_W_BIT      1
`define EPM_INFO_X_BIT      2
`define EPM_INFO_PT_LSB     8
`define EPM_INFO_PT_MSB     15
`define EPM_INFO_USED_MASK  512'h0000_0000_0000_FF07

// ----------------------------------------------------------------
// Page type and result codes
// ----------------------------------------------------------------
`define EPM_PT_REGULAR      8'h02
`define EPM_ERR_NONE        64'h0000_0000_0000_0000
`define EPM_ERR_NOT_CHG     64'h0000_0000_0000_0014
`define EPM_ERR_CONFLICT    64'h0000_0000_0000_0007
`define EPM_ARITH_CLEAR     5'h00

`endif

// ### src/epm_pkg.sv
// Types shared by the enclave page modify block.
package epm_pkg;

	// Page metadata map entry
	typedef struct packed {
		logic       valid;          // Entry holds a live page
		logic [7:0] ptype;          // Page type
		logic       pending;        // Awaiting accept
		logic       modified;       // Type change outstanding
		logic       restrict_pend;  // Restriction in progress flag
		logic       rd;             // Read right
		logic       wr;             // Write right
		logic       ex;             // Execute right
	} epm_meta_t;

	// Concurrency and owner state reported by the page cache
	typedef struct packed {
		logic gen1_access;    // First generation op on the page
		logic gen2_access;    // Another second generation op on the page
		logic gen2_in_use;    // Page held by another second generation op
		logic being_written;  // Page written by add/augment/create/reload/etc
		logic owner_init;     // Owning control struct initialised
	} epm_env_t;

	// Outcome of the check chain
	typedef enum {EPM_OK, EPM_GP, EPM_PF, EPM_CONFLICT, EPM_NOT_CHG} epm_outcome_t;

	// Sequencer states
	typedef enum {ST_IDLE, ST_PRE, ST_COPY, ST_EVAL} epm_state_t;

endpackage

// ### src/epm_check.sv
// Ordered post-copy checks on the scratch info block and page metadata.
`timescale 1ns/1ps
`include "epm_defs.svh"

module epm_check import epm_pkg::*; (
	// Operation
	input  wire logic         is_type_chg,
	input  wire logic [511:0] scratch,
	// Page state
	input  wire epm_meta_t    meta,
	input  wire epm_env_t     env,
	// Result
	output epm_outcome_t      outcome
);

	logic reserved_set;  // Any reserved info bit nonzero
	logic w_without_r;   // Write requested without read

	// ----------------------------------------------------------------
	// First failing condition wins
	// ----------------------------------------------------------------
	always_comb begin
		reserved_set = |(scratch & ~`EPM_INFO_USED_MASK);
		w_without_r  = !scratch[`EPM_INFO_R_BIT] && scratch[`EPM_INFO_W_BIT];
		outcome      = EPM_OK;
		if (!is_type_chg) begin
			if (reserved_set || w_without_r) begin
				outcome = EPM_GP;
			end else if (env.gen1_access || env.gen2_access) begin
				outcome = EPM_GP;
			end else if (!meta.valid) begin
				outcome = EPM_PF;
			end else if (env.gen2_in_use || env.being_written) begin
				outcome = EPM_CONFLICT;
			end else if (meta.pending || meta.modified) begin
				outcome = EPM_NOT_CHG;
			end else if (meta.ptype != `EPM_PT_REGULAR) begin
				outcome = EPM_PF;
			end else if (!env.owner_init) begin
				outcome = EPM_GP;
			end
		end else begin
			if (reserved_set) begin
				outcome = EPM_GP;
			end else if (env.gen1_access) begin
				outcome = EPM_CONFLICT;
			end else if (!meta.valid) begin
				outcome = EPM_PF;
			end else if (env.gen2_in_use || env.being_written) begin
				outcome = EPM_CONFLICT;
			end else if (meta.pending || meta.modified) begin
				outcome = EPM_NOT_CHG;
			end else if (!env.owner_init) begin
				outcome = EPM_GP;
			end
		end
	end

endmodule // epm_check

// ### testbench/epm_meta_store.sv
// Page metadata map model holding the entry of the target page.
`timescale 1ns/1ps
module epm_meta_store import epm_pkg::*; (
	// Clock
	input  wire logic      core_clk,
	// Bench preload
	input  wire logic      preset,
	input  wire epm_meta_t preset_val,
	// Block side
	input  wire epm_meta_t meta_wr,
	input  wire logic      meta_we,
	output epm_meta_t      meta_rd
);
	epm_meta_t entry_reg;  // Stored entry
	epm_meta_t entry_next; // Next entry

	// Entry is always visible to the block
	assign meta_rd = entry_reg;

	// Preload wins; the block commits only on its strobe
	always_comb begin
		entry_next = entry_reg;
		if (preset) begin
			entry_next = preset_val;
		end else if (meta_we) begin
			entry_next = meta_wr;
		end
	end

	// Register the entry
	always_ff @(posedge core_clk) begin
		entry_reg <= entry_next;
	end
endmodule // epm_meta_store

// ### testbench/test_enclave_page_modify_checks.sv
// Self-checking bench for the enclave page modify block.
`timescale 1ns/1ps
`include "epm_defs.svh"
module test_enclave_page_modify_checks import epm_pkg::*;;
	// Stimulus and observed signals
	logic        core_clk, rst, op_start, long_mode, gen2_present;
	logic [7:0]  op_leaf;
	logic [1:0]  op_cpl;
	logic [63:0] info_ptr, page_ptr, owner_addr_in, fault_addr, result_register, owner_struct_addr;
	logic        info_seg_ok, page_seg_ok, info_locked, page_locked, owner_locked;
	logic        info_readable, page_rw_ok, page_in_cache, page_in_enclave;
	logic [511:0] info_block;
	epm_meta_t   meta_rd, meta_wr, preset_val;
	epm_env_t    env;
	logic        meta_we, busy, done, fault_gp, fault_pf, failure_flag, preset;
	logic [4:0]  arith_flags;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	// Valid regular page, full rights
	localparam epm_meta_t BASE = {1'b1, 8'h02, 3'h0, 3'h7};

	epm_modify DUT (.core_clk, .rst, .op_start, .op_leaf, .op_cpl, .long_mode, .gen2_present,
		.info_ptr, .page_ptr, .info_seg_ok, .page_seg_ok, .info_locked, .page_locked,
		.owner_locked, .info_readable, .page_rw_ok, .page_in_cache, .page_in_enclave,
		.info_block, .owner_addr_in, .meta_rd, .env, .meta_wr, .meta_we, .busy, .done,
		.fault_gp, .fault_pf, .fault_addr, .failure_flag, .result_register, .arith_flags,
		.owner_struct_addr);
	epm_meta_store map (.core_clk, .preset, .preset_val, .meta_wr, .meta_we, .meta_rd);

	// 20 MHz clock
	initial core_clk = 1'b0;
	always #25 core_clk = ~core_clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Compare one value
	task automatic chk_v(input string nm, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Counts and verdict
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Quiet, well-formed operands
	task automatic dflt();
		op_start = 1'b0;
		op_leaf = `EPM_LEAF_RESTRICT;
		op_cpl = 2'h0;
		long_mode = 1'b1;
		gen2_present = 1'b1;
		info_ptr = 64'h1040;
		page_ptr = 64'h5000;
		{info_seg_ok, page_seg_ok, info_readable, page_rw_ok, page_in_cache, page_in_enclave} = 6'h3F;
		{info_locked, page_locked, owner_locked} = 3'h0;
		info_block = 512'h0205;
		owner_addr_in = 64'hFFFF_8000_1234_6000;
		env = 5'h01;
		preset = 1'b0;
		preset_val = BASE;
	endtask

	// Load the map entry over one edge
	task automatic set_meta(input epm_meta_t v);
		preset_val = v;
		preset = 1'b1;
		@(negedge core_clk);
		preset = 1'b0;
	endtask

	// Defaults plus a fresh entry
	task automatic fresh(input epm_meta_t v);
		dflt();
		set_meta(v);
	endtask

	// Issue one op, wait bounded for done, judge the completion
	task automatic do_op(input logic [7:0] lf, input logic eg, input logic ep, input logic ez,
		input logic [63:0] er);
		int k;
		op_leaf = lf;
		op_start = 1'b1;
		@(negedge core_clk);
		op_start = 1'b0;
		chk_v("busy", 1, busy);
		k = 0;
		while (done !== 1'b1 && k < 8) begin
			@(negedge core_clk);
			k++;
		end
		if (done !== 1'b1) begin
			n_mismatch++;
			$display("ERROR done expected 1 seen none");
			stop_test();
		end else begin
			chk_v("fault_gp", eg, fault_gp);
			chk_v("fault_pf", ep, fault_pf);
			chk_v("failure_flag", ez, failure_flag);
			chk_v("result_register", er, result_register);
			chk_v("arith_flags", 0, arith_flags);
			chk_v("busy", 0, busy);
			if (ep)
				chk_v("fault_addr", page_ptr, fault_addr);
			else if (eg)
				chk_v("fault_addr", 0, fault_addr);
			@(negedge core_clk);
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Outputs quiet after reset
	task automatic s_reset();
		chk_v("busy", 0, busy);
		chk_v("done", 0, done);
		chk_v("result_register", 0, result_register);
	endtask

	// Narrowing rights, then a mask that widens nothing
	task automatic s_restrict_ok();
		fresh(BASE);
		do_op(`EPM_LEAF_RESTRICT, 0, 0, 0, 0);
		chk_v("entry", {1'b1, 8'h02, 3'h1, 3'h5}, meta_rd);
		chk_v("owner_struct_addr", owner_addr_in, owner_struct_addr);
		info_block = 512'h0207;
		do_op(`EPM_LEAF_RESTRICT, 0, 0, 0, 0);
		chk_v("entry", {1'b1, 8'h02, 3'h1, 3'h5}, meta_rd);
	endtask

	// Pointer, residency and lock faults before the copy
	task automatic s_pre_faults();
		fresh(BASE);
		info_ptr = 64'h1020;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 0, 0);
		dflt();
		page_ptr = 64'h5800;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 0, 0);
		dflt();
		page_in_cache = 1'b0;
		do_op(`EPM_LEAF_RESTRICT, 0, 1, 0, 0);
		dflt();
		page_locked = 1'b1;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 0, 0);
		chk_v("entry", BASE, meta_rd);
	endtask

	// Faults after the copy, one cause at a time
	task automatic s_post_faults();
		fresh(BASE);
		info_block = 512'h020D;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 0, 0);
		info_block = 512'h0202;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 0, 0);
		fresh(BASE);
		env = 5'h11;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 0, 0);
		env = 5'h09;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 0, 0);
		fresh({1'b0, 8'h02, 3'h0, 3'h7});
		do_op(`EPM_LEAF_RESTRICT, 0, 1, 0, 0);
		fresh({1'b1, 8'h03, 3'h0, 3'h7});
		do_op(`EPM_LEAF_RESTRICT, 0, 1, 0, 0);
		fresh(BASE);
		env = 5'h00;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 0, 0);
		chk_v("entry", BASE, meta_rd);
	endtask

	// Error codes with the failure flag, no update
	task automatic s_errors();
		fresh(BASE);
		env = 5'h05;
		do_op(`EPM_LEAF_RESTRICT, 0, 0, 1, `EPM_ERR_CONFLICT);
		env = 5'h03;
		do_op(`EPM_LEAF_RESTRICT, 0, 0, 1, `EPM_ERR_CONFLICT);
		fresh({1'b1, 8'h02, 3'h4, 3'h7});
		do_op(`EPM_LEAF_RESTRICT, 0, 0, 1, `EPM_ERR_NOT_CHG);
		chk_v("entry", {1'b1, 8'h02, 3'h4, 3'h7}, meta_rd);
	endtask

	// Privilege, feature, type change in protected mode
	task automatic s_type_change();
		fresh(BASE);
		op_cpl = 2'h1;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		gen2_present = 1'b0;
		do_op(`EPM_LEAF_TYPE_CHG, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		long_mode = 1'b0;
		info_block = 512'h0300;
		do_op(`EPM_LEAF_TYPE_CHG, 0, 0, 0, 0);
		chk_v("entry", {1'b1, 8'h03, 3'h2, 3'h0}, meta_rd);
		chk_v("owner_struct_addr", {32'h0, owner_addr_in[31:0]}, owner_struct_addr);
		do_op(`EPM_LEAF_TYPE_CHG, 0, 0, 1, `EPM_ERR_NOT_CHG);
	endtask

	// Mode, lock, permission and leaf gates, type change faults and conflicts
	task automatic s_gate_faults();
		fresh(BASE);
		info_ptr = 64'h0001_0000_0000_1040;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		long_mode = 1'b0;
		page_seg_ok = 1'b0;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		info_locked = 1'b1;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		owner_locked = 1'b1;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		info_readable = 1'b0;
		do_op(`EPM_LEAF_RESTRICT, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		page_in_enclave = 1'b0;
		do_op(`EPM_LEAF_RESTRICT, 0, 1, 1, `EPM_ERR_NOT_CHG);
		dflt();
		op_cpl = 2'h1;
		do_op(`EPM_LEAF_TYPE_CHG, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		info_block = 512'h1_0205;
		do_op(`EPM_LEAF_TYPE_CHG, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		do_op(8'h0D, 1, 0, 1, `EPM_ERR_NOT_CHG);
		dflt();
		env = 5'h11;
		do_op(`EPM_LEAF_TYPE_CHG, 0, 0, 1, `EPM_ERR_CONFLICT);
		env = 5'h03;
		do_op(`EPM_LEAF_TYPE_CHG, 0, 0, 1, `EPM_ERR_CONFLICT);
		chk_v("entry", BASE, meta_rd);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		dflt();
		rst = 1'b1;
		repeat (5) @(negedge core_clk);
		rst = 1'b0;
		s_reset();
		s_restrict_ok();
		s_pre_faults();
		s_post_faults();
		s_errors();
		s_type_change();
		s_gate_faults();
		stop_test();
	end
endmodule // test_enclave_page_modify_checks
